/* common/icm_pkg.sv */
/*
  Shared definitions for the interval counter channel: counting modes,
  count byte formats, widths, reset values and pin synchroniser depth.
  Assumes a single 200 MHz system clock drives every user of the package.
*/
package icm_pkg;

  // ------------------------------------------------------------
  // Counting modes and count byte formats
  // ------------------------------------------------------------
  typedef enum logic [2:0]
  {
    ICM_TERMINAL,
    ICM_ONE_SHOT,
    ICM_RATE,
    ICM_SQUARE,
    ICM_SW_STROBE,
    ICM_HW_STROBE
  } icm_mode_e;

  typedef enum logic [1:0]
  {
    ICM_RW_NONE,
    ICM_RW_LSB,
    ICM_RW_MSB,
    ICM_RW_BOTH
  } icm_rw_e;

  // ------------------------------------------------------------
  // Widths, field positions and reset values
  // ------------------------------------------------------------
  localparam int          ICM_CNT_W     = 16;
  localparam int          ICM_BYTE_W    = 8;
  localparam int          ICM_LSB_POS   = 0;
  localparam int          ICM_MSB_POS   = 8;
  localparam int          ICM_SYNC_LEN  = 2;
  localparam logic [15:0] ICM_CE_RST    = 16'h0000;
  localparam logic [15:0] ICM_CR_RST    = 16'h0000;
  localparam logic [15:0] ICM_STEP_ONE  = 16'h0001;
  localparam logic [15:0] ICM_STEP_TWO  = 16'h0002;
  localparam logic [15:0] ICM_EVEN_MASK = 16'hfffe;
  localparam logic        ICM_OUT_RST   = 1'b1;

endpackage

/* rtl/icm_pin_sync.sv */
/*
  Two-stage synchroniser bank for asynchronous pins of the counter.
  Assumes the pins are quasi-static with respect to the 200 MHz clock;
  only the last stage may be read by downstream logic.
*/
module icm_pin_sync
#(
  parameter int WIDTH  = 2,
  parameter int STAGES = icm_pkg::ICM_SYNC_LEN
)
(
  input  wire logic             clk,   // System clock
  input  wire logic             rst,   // Synchronous reset, high
  input  wire logic [WIDTH-1:0] pin,   // Asynchronous pins
  output logic      [WIDTH-1:0] sync   // Synchronised levels
);

  typedef struct packed
  {
    logic [STAGES-1:0][WIDTH-1:0] stage;
  } icm_sync_s;

  icm_sync_s r;
  icm_sync_s next_r;

  // ------------------------------------------------------------
  // Shift chain
  // ------------------------------------------------------------
  always_comb
  begin
    next_r = r;
    next_r.stage[0] = pin;
    for (int i = 1; i < STAGES; i++)
    begin
      next_r.stage[i] = r.stage[i-1];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      r <= '0;
    else
      r <= next_r;
  end

  assign sync = r.stage[STAGES-1];

endmodule

/* rtl/icm_counter.sv */
/*
  One 16-bit down-counter channel of an interval timer with six modes.
  Holds the mode, the count holding register, the counting element, the
  gate trigger flag and the output level in one registered state struct.
  Assumes the host writes mode and count bytes as one-cycle strobes on
  clk, and that count_clk_pin and gate_pin are asynchronous pins much
  slower than clk (both pass a two-flop synchroniser first).
*/
// Summary of operation
// - Terminal mode: count loads on first pulse, output rises N later
// - Terminal mode: first byte halts count, output low; second byte loads
// - Terminal mode: count loads with gate low; output rises N after gate
// - One-shot: output high, low after trigger pulse, high at zero
// - One-shot: write only arms; each trigger gives N-cycle low pulse
// - One-shot: retrigger restarts N pulses; gate level leaves output alone
// - One-shot: new count waits for retrigger, then runs to expiry
// - Rate mode: output low one pulse at count 1, period N
// - Rate mode: gate level enables; gate falling forces output high
// - Rate mode: trigger or first write reloads; output low N pulses later
// - Rate mode: new count loads at period end or next triggered pulse
// - Square mode: output high first half, low second, period N
// - Square mode: gate gates counting; falling gate sets output high
// - Square mode: new count at half-cycle end or after a trigger
// - Square mode even: load count, subtract two, toggle and reload
// - Square mode odd: load count-1, high (N+1)/2, low (N-1)/2
// - Software strobe: one-pulse low strobe N+1 pulses after write
// - Software strobe: gate level enables counting, output unaffected
// - Software strobe: first byte leaves counting alone; second byte reloads, retriggers
// - Hardware strobe: load after gate rise, strobe N+1 later, retriggerable
// - Hardware strobe: new count only taken on a later trigger
// - One-shot: gate rise reloads the count; gate level ignored
// - Counting element loads and decrements on count clock falling edge
// - Gate sampled on count clock rise; trigger flag cleared after sampling
module icm_counter
#(
  parameter int CNT_W = icm_pkg::ICM_CNT_W
)
(
  input  wire logic             clk,           // System clock, 200 MHz
  input  wire logic             rst,           // Synchronous reset, high
  input  wire logic             mode_wr,       // Mode write strobe
  input  wire logic [2:0]       mode_sel,      // Counting mode 0..5
  input  wire logic [1:0]       rw_fmt,        // Count byte format
  input  wire logic             cnt_wr,        // Count byte write strobe
  input  wire logic [7:0]       cnt_byte,      // Count byte from host
  input  wire logic             count_clk_pin, // External count clock
  input  wire logic             gate_pin,      // External gate
  output logic                  cnt_out,       // Counter output level
  output logic                  null_count,    // Written count not loaded
  output logic      [CNT_W-1:0] count_now      // Counting element value
);

  typedef struct packed
  {
    icm_pkg::icm_mode_e mode;
    icm_pkg::icm_rw_e   fmt;
    logic [CNT_W-1:0]   count_holding_reg;
    logic [CNT_W-1:0]   ce;
    logic               out;
    logic               lsb_done;
    logic               have_count;
    logic               load_pend;
    logic               hold;
    logic               newcnt;
    logic               trig_flag;
    logic               trig_seen;
    logic               gate_lvl;
    logic               gate_d;
    logic               ck_d;
    logic               odd_wait;
    logic               strobed;
  } icm_state_s;

  icm_state_s r;
  icm_state_s next_r;

  logic [1:0] pins_sync;
  logic       ck_s;
  logic       gate_s;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  icm_pin_sync
  #(
    .WIDTH  (2),
    .STAGES (icm_pkg::ICM_SYNC_LEN)
  )
  u_sync
  (
    .clk  (clk),
    .rst  (rst),
    .pin  ({gate_pin, count_clk_pin}),
    .sync (pins_sync)
  );

  assign ck_s   = pins_sync[0];
  assign gate_s = pins_sync[1];

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Values 6 and 7 alias the two periodic modes
  function automatic icm_pkg::icm_mode_e decode_mode(input logic [2:0] v);
    icm_pkg::icm_mode_e m;
    m = icm_pkg::icm_mode_e'({1'b0, v[1:0]});
    if (v == 3'h4)
      m = icm_pkg::ICM_SW_STROBE;
    else if (v == 3'h5)
      m = icm_pkg::ICM_HW_STROBE;
    else if (v[1])
      m = icm_pkg::icm_mode_e'({1'b0, v[1:0]});
    return m;
  endfunction

  function automatic logic is_periodic(input icm_pkg::icm_mode_e m);
    return (m == icm_pkg::ICM_RATE) || (m == icm_pkg::ICM_SQUARE);
  endfunction

  // Square mode loads the even part of the count
  function automatic logic [CNT_W-1:0] sq_load(input logic [CNT_W-1:0] c);
    return c & icm_pkg::ICM_EVEN_MASK;
  endfunction

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    logic ck_rise;
    logic ck_fall;
    logic gate_rise;
    logic gate_fall;
    logic commit;
    logic trig;
    ck_rise   = ck_s & ~r.ck_d;
    ck_fall   = ~ck_s & r.ck_d;
    gate_rise = gate_s & ~r.gate_d;
    gate_fall = ~gate_s & r.gate_d;
    commit    = 1'b0;
    trig      = r.trig_seen & r.have_count;
    next_r    = r;
    next_r.ck_d   = ck_s;
    next_r.gate_d = gate_s;

    if (ck_rise)
    begin
      next_r.gate_lvl  = gate_s;
      next_r.trig_seen = r.trig_flag;
      next_r.trig_flag = 1'b0;
    end
    // A trigger in the sampling cycle is kept
    if (gate_rise)
      next_r.trig_flag = 1'b1;

    // counting element moves on falling edges only
    if (ck_fall)
    begin
      next_r.trig_seen = 1'b0;
      case (r.mode)
        icm_pkg::ICM_TERMINAL:
        begin
          if (r.load_pend)
          begin
            next_r.ce        = r.count_holding_reg;
            next_r.load_pend = 1'b0;
            next_r.newcnt    = 1'b0;
          end
          else if (r.gate_lvl && !r.hold && r.have_count)
          begin
            next_r.ce = r.ce - icm_pkg::ICM_STEP_ONE;
            if (r.ce == icm_pkg::ICM_STEP_ONE)
              next_r.out = 1'b1;
          end
        end
        icm_pkg::ICM_ONE_SHOT:
        begin
          if (trig)
          begin
            // each trigger reloads the latest count
            next_r.ce     = r.count_holding_reg;
            next_r.out    = 1'b0;
            next_r.newcnt = 1'b0;
          end
          else
          begin
            next_r.ce = r.ce - icm_pkg::ICM_STEP_ONE;
            if (r.ce == icm_pkg::ICM_STEP_ONE)
              next_r.out = 1'b1;
          end
        end
        icm_pkg::ICM_RATE:
        begin
          // trigger or first write forces a reload
          if (r.load_pend || trig)
          begin
            next_r.ce        = r.count_holding_reg;
            next_r.out       = 1'b1;
            next_r.load_pend = 1'b0;
            next_r.newcnt    = 1'b0;
          end
          else if (r.gate_lvl && r.have_count)
          begin
            // one low pulse at count one, then reload
            if (r.ce == icm_pkg::ICM_STEP_ONE)
            begin
              next_r.ce     = r.count_holding_reg;
              next_r.out    = 1'b1;
              next_r.newcnt = 1'b0;
            end
            else
            begin
              next_r.ce = r.ce - icm_pkg::ICM_STEP_ONE;
              if (r.ce == icm_pkg::ICM_STEP_TWO)
                next_r.out = 1'b0;
            end
          end
        end
        icm_pkg::ICM_SQUARE:
        begin
          // trigger reloads on the next pulse
          if (r.load_pend || trig)
          begin
            next_r.ce        = sq_load(r.count_holding_reg);
            next_r.out       = 1'b1;
            next_r.odd_wait  = 1'b0;
            next_r.load_pend = 1'b0;
            next_r.newcnt    = 1'b0;
          end
          else if (r.gate_lvl && r.have_count)
          begin
            // extra pulse before the falling edge
            if (r.odd_wait)
            begin
              next_r.out      = 1'b0;
              next_r.odd_wait = 1'b0;
              next_r.ce       = sq_load(r.count_holding_reg);
              next_r.newcnt   = 1'b0;
            end
            else if (r.ce == icm_pkg::ICM_STEP_TWO)
            begin
              if (r.out && r.count_holding_reg[0])
              begin
                next_r.odd_wait = 1'b1;
                next_r.ce       = '0;
              end
              else
              begin
                // half-cycle end takes the latest count
                next_r.out    = ~r.out;
                next_r.ce     = sq_load(r.count_holding_reg);
                next_r.newcnt = 1'b0;
              end
            end
            else
              next_r.ce = r.ce - icm_pkg::ICM_STEP_TWO;
          end
        end
        icm_pkg::ICM_SW_STROBE:
        begin
          // Strobe lasts exactly one pulse
          next_r.out = 1'b1;
          if (r.load_pend)
          begin
            next_r.ce        = r.count_holding_reg;
            next_r.load_pend = 1'b0;
            next_r.newcnt    = 1'b0;
            next_r.strobed   = 1'b0;
          end
          else if (r.gate_lvl && r.have_count)
          begin
            next_r.ce = r.ce - icm_pkg::ICM_STEP_ONE;
            if (r.ce == icm_pkg::ICM_STEP_ONE && !r.strobed)
            begin
              next_r.out     = 1'b0;
              next_r.strobed = 1'b1;
            end
          end
        end
        icm_pkg::ICM_HW_STROBE:
        begin
          next_r.out = 1'b1;
          // only a trigger loads the count
          if (trig)
          begin
            next_r.ce        = r.count_holding_reg;
            next_r.newcnt    = 1'b0;
            next_r.strobed   = 1'b0;
            next_r.load_pend = 1'b1;
          end
          else
          begin
            next_r.ce = r.ce - icm_pkg::ICM_STEP_ONE;
            if (r.ce == icm_pkg::ICM_STEP_ONE && !r.strobed && r.load_pend)
            begin
              next_r.out     = 1'b0;
              next_r.strobed = 1'b1;
            end
          end
        end
        default:
        begin
          next_r.out = 1'b1;
        end
      endcase
    end

    // falling gate releases the output without a count clock
    if (gate_fall && is_periodic(r.mode) && !r.out)
    begin
      next_r.out      = 1'b1;
      next_r.odd_wait = 1'b0;
    end

    // ------------------------------------------------------------
    // Host count writes
    // ------------------------------------------------------------
    if (cnt_wr && r.fmt != icm_pkg::ICM_RW_NONE)
    begin
      case (r.fmt)
        icm_pkg::ICM_RW_LSB:
        begin
          next_r.count_holding_reg = {{(CNT_W-8){1'b0}}, cnt_byte};
          commit = 1'b1;
        end
        icm_pkg::ICM_RW_MSB:
        begin
          next_r.count_holding_reg = {cnt_byte, {(CNT_W-8){1'b0}}};
          commit = 1'b1;
        end
        default:
        begin
          if (!r.lsb_done)
          begin
            next_r.count_holding_reg[icm_pkg::ICM_LSB_POS +: 8] = cnt_byte;
            next_r.lsb_done = 1'b1;
            // first byte halts terminal counting at once
            if (r.mode == icm_pkg::ICM_TERMINAL)
            begin
              next_r.hold = 1'b1;
              next_r.out  = 1'b0;
            end
          end
          else
          begin
            next_r.count_holding_reg[icm_pkg::ICM_MSB_POS +: 8] = cnt_byte;
            next_r.lsb_done = 1'b0;
            commit = 1'b1;
          end
        end
      endcase
    end

    if (commit)
    begin
      next_r.have_count = 1'b1;
      next_r.newcnt     = 1'b1;
      case (r.mode)
        icm_pkg::ICM_TERMINAL:
        begin
          next_r.hold      = 1'b0;
          next_r.out       = 1'b0;
          next_r.load_pend = 1'b1;
        end
        icm_pkg::ICM_SW_STROBE:
        begin
          next_r.load_pend = 1'b1;
        end
        icm_pkg::ICM_RATE, icm_pkg::ICM_SQUARE:
        begin
          // later counts wait for period end (rate) or half-cycle end (square)
          if (!r.have_count)
            next_r.load_pend = 1'b1;
        end
        default:
        begin
          // one-shot and hardware strobe are only armed
          next_r.load_pend = r.load_pend;
        end
      endcase
    end

    // ------------------------------------------------------------
    // Mode write resets control logic
    // ------------------------------------------------------------
    if (mode_wr)
    begin
      next_r.mode       = decode_mode(mode_sel);
      next_r.fmt        = icm_pkg::icm_rw_e'(rw_fmt);
      next_r.out        = (decode_mode(mode_sel) != icm_pkg::ICM_TERMINAL);
      next_r.lsb_done   = 1'b0;
      next_r.have_count = 1'b0;
      next_r.load_pend  = 1'b0;
      next_r.hold       = 1'b0;
      next_r.newcnt     = 1'b0;
      next_r.trig_flag  = 1'b0;
      next_r.trig_seen  = 1'b0;
      next_r.odd_wait   = 1'b0;
      next_r.strobed    = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      r                   <= '0;
      r.mode              <= icm_pkg::ICM_TERMINAL;
      r.fmt               <= icm_pkg::ICM_RW_NONE;
      r.count_holding_reg <= icm_pkg::ICM_CR_RST;
      r.ce                <= icm_pkg::ICM_CE_RST;
      r.out               <= icm_pkg::ICM_OUT_RST;
    end
    else
      r <= next_r;
  end

  assign cnt_out    = r.out;
  assign null_count = r.newcnt;
  assign count_now  = r.ce;

endmodule

/* test/icm_counter_assertions.sv */
/*
  Checker for the interval counter channel, bound to icm_counter.
  Assumes the pins change only after clk edges and are held for at least
  three clk cycles, as the count clock and gate source provides.
*/
module icm_counter_assertions
#(
  parameter int CNT_W = 16
)
(
  input wire logic             clk,           // System clock
  input wire logic             rst,           // Synchronous reset, high
  input wire logic             mode_wr,       // Mode write strobe
  input wire logic [2:0]       mode_sel,      // Counting mode
  input wire logic [1:0]       rw_fmt,        // Count byte format
  input wire logic             cnt_wr,        // Count byte strobe
  input wire logic [7:0]       cnt_byte,      // Count byte
  input wire logic             count_clk_pin, // Count clock pin
  input wire logic             gate_pin,      // Gate pin
  input wire logic             cnt_out,       // Counter output
  input wire logic             null_count,    // Count not yet loaded
  input wire logic [CNT_W-1:0] count_now      // Counting element
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------
  logic [2:0]  mode;
  logic [7:0]  ch;
  logic [11:0] gh;
  logic        recent_fall;

  // Wide window covers synchroniser plus edge detect latency
  assign recent_fall = |(ch[7:1] & ~ch[6:0]);

  always_ff @(posedge clk)
  begin
    ch <= {ch[6:0], count_clk_pin};
    gh <= {gh[10:0], gate_pin};
    if (rst)
      mode <= 3'h0;
    else if (mode_wr)
      mode <= (mode_sel > 3'h5) ? mode_sel - 3'h4 : mode_sel;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  sequence s_gate_drop;
    (mode == 3'h2 || mode == 3'h3) && gh[1] && !gh[0] && !cnt_out;
  endsequence

  sequence s_out_high;
    ##[1:8] cnt_out;
  endsequence

  AST_RESET_STATE: assert property (disable iff (1'b0)
    rst |=> cnt_out && !null_count && count_now == 16'h0000)
    else $error("state after reset wrong");
  AST_MODE_INIT: assert property (mode_wr && !cnt_wr |=>
    cnt_out == (mode_sel != 3'h0))
    else $error("output after mode write wrong");
  AST_NULL_SET: assert property ($rose(null_count) |->
    $past(cnt_wr))
    else $error("null count rose without a count write");
  AST_NULL_CLEAR: assert property ($fell(null_count) |->
    recent_fall || $past(mode_wr))
    else $error("count loaded without a count clock fall");
  AST_COUNT_ON_FALL: assert property ($changed(count_now) |->
    recent_fall || $past(mode_wr))
    else $error("count moved without a count clock fall");
  AST_TERM_LOW_ON_WRITE: assert property (mode == 3'h0 &&
    $fell(cnt_out) |-> $past(mode_wr) || $past(cnt_wr))
    else $error("terminal output fell without a write");
  AST_GATE_NO_EFFECT: assert property (mode inside {3'h1, 3'h4, 3'h5}
    && $changed(cnt_out) |-> recent_fall || $past(mode_wr))
    else $error("output moved without a count clock fall");
  AST_GATE_FALL_HIGH: assert property (s_gate_drop |-> s_out_high)
    else $error("gate fall left output low");
  AST_GATE_LOW_HOLDS: assert property (mode inside {3'h0, 3'h2, 3'h3,
    3'h4} && gh == 12'h000 && !$past(null_count) && !$past(mode_wr)
    && !$past(cnt_wr) |-> $stable(count_now))
    else $error("count moved with gate low");
endmodule

bind icm_counter icm_counter_assertions #(.CNT_W(CNT_W))
  i_icm_counter_assertions (.clk(clk), .rst(rst), .mode_wr(mode_wr),
  .mode_sel(mode_sel), .rw_fmt(rw_fmt), .cnt_wr(cnt_wr),
  .cnt_byte(cnt_byte), .count_clk_pin(count_clk_pin),
  .gate_pin(gate_pin), .cnt_out(cnt_out), .null_count(null_count),
  .count_now(count_now));

/* test/icm_far_model.sv */
/*
  Count clock and gate source standing outside the counter channel.
  Assumes requests arrive as one-cycle strobes on clk; the count clock
  stands low between pulses.
*/
module icm_far_model
(
  input  wire logic clk,           // System clock
  input  wire logic rst,           // Synchronous reset, high
  input  wire logic pulse_req,     // Request one count clock pulse
  input  wire logic gate_lvl,      // Requested gate level
  output logic      count_clk_pin, // Count clock, idles low
  output logic      gate_pin,      // Gate level
  output logic      busy           // Pulse in progress
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] ph;

  assign busy = (ph != 4'h0);

  // Long low phase lets the counter settle before the next pulse
  always_ff @(posedge clk)
  begin
    gate_pin <= gate_lvl;
    if (rst)
      ph <= 4'h0;
    else if (busy)
      ph <= (ph == 4'hc) ? 4'h0 : ph + 4'h1;
    else if (pulse_req)
      ph <= 4'h1;
    count_clk_pin <= !rst && (busy ? ph < 4'h4 : pulse_req);
  end
endmodule

/* test/icm_counter_tb.sv */
/*
  Self-checking bench for the interval counter channel.
  Assumes the far model shapes count clock pulses and the gate level.
*/
module icm_counter_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        mode_wr = 1'b0;
  logic [2:0]  mode_sel = 3'h0;
  logic [1:0]  rw_fmt = 2'h0;
  logic        cnt_wr = 1'b0;
  logic [7:0]  cnt_byte = 8'h00;
  logic        pulse_req = 1'b0;
  logic        gate_lvl = 1'b0;
  logic        count_clk_pin;
  logic        gate_pin;
  logic        busy;
  logic        cnt_out;
  logic        null_count;
  logic [15:0] count_now;
  int          fail_count = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  icm_counter i_icm_counter (.clk(clk), .rst(rst), .mode_wr(mode_wr),
    .mode_sel(mode_sel), .rw_fmt(rw_fmt), .cnt_wr(cnt_wr),
    .cnt_byte(cnt_byte), .count_clk_pin(count_clk_pin),
    .gate_pin(gate_pin), .cnt_out(cnt_out), .null_count(null_count),
    .count_now(count_now));

  icm_far_model i_icm_far_model (.clk(clk), .rst(rst),
    .pulse_req(pulse_req), .gate_lvl(gate_lvl),
    .count_clk_pin(count_clk_pin), .gate_pin(gate_pin), .busy(busy));

  initial
  begin
    forever #2.5 clk = ~clk;
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic stop_test();
    $display("mismatches %0d, comparisons %0d", fail_count,
      samples_checked);
    if (fail_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask

  task automatic wr_mode(input logic [2:0] m, input logic [1:0] f);
    @(posedge clk);
    mode_wr  <= 1'b1;
    mode_sel <= m;
    rw_fmt   <= f;
    @(posedge clk);
    mode_wr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic wr_byte(input logic [7:0] b);
    @(posedge clk);
    cnt_wr   <= 1'b1;
    cnt_byte <= b;
    @(posedge clk);
    cnt_wr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic gate(input logic v);
    @(posedge clk);
    gate_lvl <= v;
    repeat (8) @(posedge clk);
    #1;
  endtask

  task automatic trig();
    gate(1'b0);
    gate(1'b1);
  endtask

  task automatic pulse();
    @(posedge clk);
    pulse_req <= 1'b1;
    @(posedge clk);
    pulse_req <= 1'b0;
    for (int i = 0; i < 20; i++)
    begin
      @(posedge clk);
      #1;
      if (busy === 1'b0)
        break;
    end
  endtask

  // Bit i of exp is the output level after pulse i
  task automatic seq(input int n, input logic [15:0] exp);
    for (int i = 0; i < n; i++)
    begin
      pulse();
      chk({15'h0000, cnt_out}, {15'h0000, exp[i]});
    end
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_terminal();
    wr_mode(3'h0, 2'h1);
    chk(cnt_out, 1'b0);
    wr_byte(8'h03);
    chk(null_count, 1'b1);
    pulse();
    chk(count_now, 16'h0003);
    chk(null_count, 1'b0);
    seq(3, 16'h0004);
    wr_mode(3'h0, 2'h3);
    wr_byte(8'h02);
    wr_byte(8'h00);
    seq(3, 16'h0004);
    wr_byte(8'h05);
    chk(cnt_out, 1'b0);
    pulse();
    chk(count_now, 16'h0000);
    wr_byte(8'h00);
    seq(6, 16'h0020);
    gate(1'b0);
    wr_byte(8'h02);
    wr_byte(8'h00);
    pulse();
    chk(count_now, 16'h0002);
    pulse();
    chk(count_now, 16'h0002);
    gate(1'b1);
    seq(2, 16'h0002);
  endtask

  task automatic t_one_shot();
    wr_mode(3'h1, 2'h1);
    chk(cnt_out, 1'b1);
    wr_byte(8'h03);
    seq(2, 16'h0003);
    trig();
    seq(4, 16'h0008);
    trig();
    seq(4, 16'h0008);
    trig();
    seq(2, 16'h0000);
    trig();
    seq(4, 16'h0008);
    trig();
    seq(1, 16'h0000);
    wr_byte(8'h05);
    seq(3, 16'h0004);
    trig();
    seq(6, 16'h0020);
  endtask

  task automatic t_rate();
    // Value 6 aliases the rate mode
    wr_mode(3'h6, 2'h1);
    wr_byte(8'h03);
    seq(7, 16'h005b);
    seq(2, 16'h0001);
    gate(1'b0);
    chk(cnt_out, 1'b1);
    seq(3, 16'h0007);
    gate(1'b1);
    seq(3, 16'h0003);
    seq(1, 16'h0001);
    wr_byte(8'h02);
    seq(4, 16'h0005);
    chk(count_now, 16'h0001);
  endtask

  task automatic t_square();
    wr_mode(3'h3, 2'h1);
    wr_byte(8'h04);
    seq(5, 16'h0013);
    // Value 7 aliases the square mode
    wr_mode(3'h7, 2'h1);
    wr_byte(8'h05);
    seq(6, 16'h0027);
    seq(3, 16'h0003);
    gate(1'b0);
    chk(cnt_out, 1'b1);
    gate(1'b1);
    wr_byte(8'h04);
    seq(3, 16'h0003);
    wr_byte(8'h06);
    seq(5, 16'h000e);
  endtask

  task automatic t_strobes();
    wr_mode(3'h4, 2'h3);
    wr_byte(8'h02);
    wr_byte(8'h00);
    seq(4, 16'h000b);
    wr_byte(8'h03);
    seq(1, 16'h0001);
    chk(count_now, 16'hfffe);
    wr_byte(8'h00);
    seq(5, 16'h0017);
    gate(1'b0);
    seq(2, 16'h0003);
    chk(count_now, 16'hffff);
    gate(1'b1);
    wr_mode(3'h5, 2'h1);
    wr_byte(8'h02);
    seq(3, 16'h0007);
    trig();
    seq(4, 16'h000b);
    trig();
    seq(1, 16'h0001);
    wr_byte(8'h04);
    trig();
    seq(6, 16'h002f);
  endtask

  // ------------------------------------------------------------
  // Main sequence and hang guard
  // ------------------------------------------------------------
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      fail_count++;
      stop_test();
    end
  end

  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk(cnt_out, 1'b1);
    chk(null_count, 1'b0);
    chk(count_now, 16'h0000);
    // Format none: count bytes are ignored
    wr_mode(3'h0, 2'h0);
    wr_byte(8'h03);
    chk(null_count, 1'b0);
    gate(1'b1);
    t_terminal();
    t_one_shot();
    t_rate();
    t_square();
    t_strobes();
    stop_test();
  end
endmodule
